// ---- design/pdd_pkg.sv ----
package pdd_pkg;
  // instruction word fields
  localparam int OPC_HI      = 31;
  localparam int OPC_LO      = 28;
  localparam int CNT1_HI     = 11;
  localparam int CNT1_LO     = 0;
  localparam int BEN_HI      = 15;
  localparam int BEN_LO      = 12;
  localparam int OFS_HI      = 13;
  localparam int OFS_LO      = 12;
  localparam int STS_CLR_HI  = 19;
  localparam int STS_CLR_LO  = 16;
  localparam int STS_SET_HI  = 23;
  localparam int STS_SET_LO  = 20;
  localparam int IRQ_BIT     = 24;
  localparam int LAST_BIT    = 26;
  localparam int FIRST_BIT   = 27;
  localparam int CNT3_HI     = 27;
  localparam int CNT3_LO     = 16;

  // opcodes handled here
  localparam logic [3:0] OPC_CONT_WRITE  = 4'h5;
  localparam logic [3:0] OPC_DISCARD     = 4'h2;
  localparam logic [3:0] OPC_PLANAR_DISC = 4'ha;
  localparam logic [3:0] OPC_LUMA_WRITE  = 4'hb;

  localparam logic [3:0]  STATUS_RESET = 4'h0;
  localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;

  typedef enum logic [2:0] {
    PDD_CMD_NONE        = 3'h0,
    PDD_CMD_CONT_WRITE  = 3'h1,
    PDD_CMD_DISCARD     = 3'h2,
    PDD_CMD_PLANAR_DISC = 3'h3,
    PDD_CMD_LUMA_WRITE  = 3'h4
  } pdd_cmd_t;

  typedef enum logic [2:0] {
    PDD_FETCH0 = 3'h0,
    PDD_FETCH1 = 3'h1,
    PDD_FETCH2 = 3'h2,
    PDD_EXEC   = 3'h3,
    PDD_HALT   = 3'h4
  } pdd_state_t;
endpackage : pdd_pkg

// ---- design/pdd_sync3.sv ----
`timescale 1ns/100ps
module pdd_sync3 (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } pdd_sync_t;

  pdd_sync_t q;
  pdd_sync_t d;

  always_comb begin
    d    = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // accept a change once stages two and three agree
    if (q.s2 == q.s3) begin
      d.out = q.s3;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.out;
endmodule : pdd_sync3

// ---- design/pdd_decoder.sv ----
`timescale 1ns/100ps
module pdd_decoder (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             program_enable,
  input  wire logic             instr_valid,
  input  wire logic [31:0]      instr_word,
  input  wire logic             exec_done,
  input  wire logic             fifo_line_end,
  output logic                  instr_ready,
  output logic                  cmd_valid,
  output pdd_pkg::pdd_cmd_t     cmd_op,
  output logic [11:0]           cmd_count1,
  output logic [11:0]           cmd_count2,
  output logic [11:0]           cmd_count3,
  output logic [3:0]            cmd_byte_en,
  output logic [1:0]            cmd_offset,
  output logic [31:0]           cmd_addr,
  output logic                  cmd_line_first,
  output logic                  cmd_line_last,
  output logic [3:0]            program_status_flags,
  output logic                  done_irq,
  output logic                  error_irq,
  output logic                  halted,
  output logic                  aborting
);
  typedef struct packed {
    pdd_pkg::pdd_state_t st;
    logic                ready;
    logic                cmd_valid;
    pdd_pkg::pdd_cmd_t   op;
    logic [11:0]         cnt1;
    logic [11:0]         cnt2;
    logic [11:0]         cnt3;
    logic [3:0]          ben;
    logic [1:0]          ofs;
    logic [31:0]         addr;
    logic                first;
    logic                last;
    logic [3:0]          sts_clr;
    logic [3:0]          sts_set;
    logic                irq_req;
    logic [31:0]         target;
    logic [3:0]          status;
    logic                done_irq;
    logic                err_irq;
    logic                skip;
    logic                en_prev;
    logic                halted;
  } pdd_dec_t;

  pdd_dec_t q;
  pdd_dec_t d;
  logic     en_s;
  logic     accept;
  logic     issue;
  logic [3:0] opc;

  pdd_sync3 u_en_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (program_enable),
    .sync_out (en_s)
  );

  assign accept = instr_valid && q.ready;
  assign opc    = instr_word[pdd_pkg::OPC_HI:pdd_pkg::OPC_LO];

  always_comb begin
    d           = q;
    issue       = 1'b0;
    d.cmd_valid = 1'b0;
    d.done_irq  = 1'b0;
    d.err_irq   = 1'b0;
    d.en_prev   = en_s;
    case (q.st)
      pdd_pkg::PDD_FETCH0: begin
        if (accept) begin
          d.cnt1    = instr_word[pdd_pkg::CNT1_HI:pdd_pkg::CNT1_LO];
          d.ben     = instr_word[pdd_pkg::BEN_HI:pdd_pkg::BEN_LO];
          d.ofs     = instr_word[pdd_pkg::OFS_HI:pdd_pkg::OFS_LO];
          d.sts_clr = instr_word[pdd_pkg::STS_CLR_HI:pdd_pkg::STS_CLR_LO];
          d.sts_set = instr_word[pdd_pkg::STS_SET_HI:pdd_pkg::STS_SET_LO];
          d.irq_req = instr_word[pdd_pkg::IRQ_BIT];
          d.first   = instr_word[pdd_pkg::FIRST_BIT];
          d.last    = instr_word[pdd_pkg::LAST_BIT];
          d.cnt2    = '0;
          d.cnt3    = '0;
          if (opc == pdd_pkg::OPC_CONT_WRITE) begin
            d.op   = pdd_pkg::PDD_CMD_CONT_WRITE;
            d.addr = q.target;
            issue  = 1'b1;
          end else if (opc == pdd_pkg::OPC_DISCARD) begin
            d.op  = pdd_pkg::PDD_CMD_DISCARD;
            d.addr = q.target;
            issue = 1'b1;
          end else if (opc == pdd_pkg::OPC_PLANAR_DISC) begin
            d.op = pdd_pkg::PDD_CMD_PLANAR_DISC;
            d.st = pdd_pkg::PDD_FETCH1;
          end else if (opc == pdd_pkg::OPC_LUMA_WRITE) begin
            d.op = pdd_pkg::PDD_CMD_LUMA_WRITE;
            d.st = pdd_pkg::PDD_FETCH1;
          end else begin
            d.err_irq = 1'b1;
            d.st      = pdd_pkg::PDD_HALT;
          end
        end
      end
      pdd_pkg::PDD_FETCH1: begin
        if (accept) begin
          d.cnt2 = instr_word[pdd_pkg::CNT1_HI:pdd_pkg::CNT1_LO];
          d.cnt3 = instr_word[pdd_pkg::CNT3_HI:pdd_pkg::CNT3_LO];
          if (q.op == pdd_pkg::PDD_CMD_PLANAR_DISC) begin
            d.addr = q.target;
            issue  = 1'b1;
          end else begin
            d.st = pdd_pkg::PDD_FETCH2;
          end
        end
      end
      pdd_pkg::PDD_FETCH2: begin
        if (accept) begin
          d.addr   = instr_word;
          d.target = instr_word;
          issue    = 1'b1;
        end
      end
      pdd_pkg::PDD_EXEC: begin
        if (fifo_line_end && !q.last) begin
          d.skip = 1'b1;
          d.st   = pdd_pkg::PDD_FETCH0;
        end else if (exec_done) begin
          d.status   = (q.status & ~q.sts_clr) | q.sts_set;
          d.done_irq = q.irq_req;
          if (q.op == pdd_pkg::PDD_CMD_CONT_WRITE || q.op == pdd_pkg::PDD_CMD_DISCARD ||
              q.op == pdd_pkg::PDD_CMD_LUMA_WRITE) begin
            d.target = q.target + {20'h00000, q.cnt1};
          end
          d.st = pdd_pkg::PDD_FETCH0;
        end
      end
      pdd_pkg::PDD_HALT: begin
        if (en_s && !q.en_prev) begin
          d.st   = pdd_pkg::PDD_FETCH0;
          d.skip = 1'b0;
        end
      end
      default: begin
        d.st = pdd_pkg::PDD_FETCH0;
      end
    endcase
    if (issue) begin
      if (q.skip) begin
        d.st = pdd_pkg::PDD_FETCH0;
        if (d.last) begin
          d.skip = 1'b0;
        end
      end else begin
        d.cmd_valid = 1'b1;
        d.st        = pdd_pkg::PDD_EXEC;
      end
    end
    if (!en_s && q.st != pdd_pkg::PDD_HALT) begin
      d.st        = pdd_pkg::PDD_FETCH0;
      d.cmd_valid = 1'b0;
      d.skip      = 1'b0;
    end
    d.ready = en_s && (d.st == pdd_pkg::PDD_FETCH0 || d.st == pdd_pkg::PDD_FETCH1 ||
                       d.st == pdd_pkg::PDD_FETCH2);
    d.halted = (d.st == pdd_pkg::PDD_HALT);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q        <= '0;
      q.status <= pdd_pkg::STATUS_RESET;
      q.target <= pdd_pkg::ADDR_RESET;
    end else begin
      q <= d;
    end
  end

  assign instr_ready          = q.ready;
  assign cmd_valid            = q.cmd_valid;
  assign cmd_op               = q.op;
  assign cmd_count1           = q.cnt1;
  assign cmd_count2           = q.cnt2;
  assign cmd_count3           = q.cnt3;
  assign cmd_byte_en          = q.ben;
  assign cmd_offset           = q.ofs;
  assign cmd_addr             = q.addr;
  assign cmd_line_first       = q.first;
  assign cmd_line_last        = q.last;
  assign program_status_flags = q.status;
  assign done_irq             = q.done_irq;
  assign error_irq            = q.err_irq;
  assign halted               = q.halted;
  assign aborting             = q.skip;

  logic w0_acc;
  assign w0_acc = accept && q.st == pdd_pkg::PDD_FETCH0 && en_s;

  property p_cpw_issue;
    @(posedge ref_clk) disable iff (reset)
      w0_acc && opc == pdd_pkg::OPC_CONT_WRITE && !q.skip |=>
        cmd_valid && cmd_op == pdd_pkg::PDD_CMD_CONT_WRITE && !instr_ready;
  endproperty
  a_cpw_issue: assert property (p_cpw_issue) else $error("packed write not issued");

  property p_cpw_addr;
    @(posedge ref_clk) disable iff (reset)
      w0_acc && opc == pdd_pkg::OPC_CONT_WRITE |=> cmd_addr == $past(q.target);
  endproperty
  a_cpw_addr: assert property (p_cpw_addr) else $error("packed write address wrong");

  property p_cpw_fields;
    @(posedge ref_clk) disable iff (reset)
      w0_acc && opc == pdd_pkg::OPC_CONT_WRITE |=>
        cmd_count1 == $past(instr_word[11:0]) && cmd_byte_en == $past(instr_word[15:12]);
  endproperty
  a_cpw_fields: assert property (p_cpw_fields) else $error("packed write fields wrong");

  property p_disc_fields;
    @(posedge ref_clk) disable iff (reset)
      w0_acc && opc == pdd_pkg::OPC_DISCARD |=>
        cmd_count1 == $past(instr_word[11:0]) && cmd_offset == $past(instr_word[13:12]);
  endproperty
  a_disc_fields: assert property (p_disc_fields) else $error("discard fields wrong");

  sequence s_pdisc_w0;
    w0_acc && opc == pdd_pkg::OPC_PLANAR_DISC && !q.skip;
  endsequence
  sequence s_pdisc_w1;
    instr_valid && instr_ready && en_s ##1
      cmd_valid && cmd_count2 == $past(instr_word[11:0]) &&
      cmd_count3 == $past(instr_word[27:16]);
  endsequence
  property p_pdisc;
    @(posedge ref_clk) disable iff (reset)
      s_pdisc_w0 ##1 (instr_valid && en_s) |-> s_pdisc_w1;
  endproperty
  a_pdisc: assert property (p_pdisc) else $error("planar discard counts wrong");

  property p_luma_addr;
    @(posedge ref_clk) disable iff (reset)
      accept && en_s && q.st == pdd_pkg::PDD_FETCH2 && !q.skip |=>
        cmd_valid && cmd_addr == $past(instr_word);
  endproperty
  a_luma_addr: assert property (p_luma_addr) else $error("luma address wrong");

  property p_err_halt;
    @(posedge ref_clk) disable iff (reset)
      w0_acc && (opc == 4'h0 || opc == 4'hf) |=> error_irq && halted ##1 !error_irq;
  endproperty
  a_err_halt: assert property (p_err_halt) else $error("bad opcode did not halt");

  property p_halt_hold;
    @(posedge ref_clk) disable iff (reset)
      halted && !(en_s && !q.en_prev) |=> halted && !instr_ready && !cmd_valid;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("left halt without enable");

  property p_abort;
    @(posedge ref_clk) disable iff (reset)
      q.st == pdd_pkg::PDD_EXEC && fifo_line_end && !cmd_line_last && en_s |=>
        aborting && program_status_flags == $past(program_status_flags);
  endproperty
  a_abort: assert property (p_abort) else $error("early line end not aborted");

  property p_status;
    @(posedge ref_clk) disable iff (reset)
      q.st == pdd_pkg::PDD_EXEC && exec_done && !fifo_line_end && en_s |=>
        program_status_flags == (($past(q.status) & ~$past(q.sts_clr)) | $past(q.sts_set))
        && done_irq == $past(q.irq_req);
  endproperty
  a_status: assert property (p_status) else $error("completion status wrong");
endmodule : pdd_decoder

// ---- sim/pdd_exec_model.sv ----
`timescale 1ns/100ps
module pdd_exec_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       cmd_valid,
  input  wire logic [3:0] delay,
  input  wire logic       early_end,
  output logic            exec_done,
  output logic            fifo_line_end
);
  logic [3:0] cnt;
  logic       pend;
  initial begin
    exec_done = 1'b0;
    fifo_line_end = 1'b0;
    pend = 1'b0;
    cnt = 4'h0;
  end
  // one answer per command, delay+1 falling edges after it is seen
  always @(negedge ref_clk) begin
    exec_done <= 1'b0;
    fifo_line_end <= 1'b0;
    if (reset) begin
      pend = 1'b0;
    end else if (cmd_valid === 1'b1) begin
      pend = 1'b1;
      cnt = delay;
    end else if (pend && cnt != 4'h0) begin
      cnt = cnt - 4'h1;
    end else if (pend) begin
      pend = 1'b0;
      if (early_end) fifo_line_end <= 1'b1;
      else exec_done <= 1'b1;
    end
  end
endmodule : pdd_exec_model

// ---- sim/pdd_decoder_tb_top.sv ----
`timescale 1ns/100ps
module pdd_decoder_tb_top;
  logic              ref_clk;
  logic              reset;
  logic              program_enable;
  logic              instr_valid;
  logic [31:0]       instr_word;
  logic              exec_done;
  logic              fifo_line_end;
  logic              instr_ready;
  logic              cmd_valid;
  pdd_pkg::pdd_cmd_t cmd_op;
  logic [11:0]       cmd_count1;
  logic [11:0]       cmd_count2;
  logic [11:0]       cmd_count3;
  logic [3:0]        cmd_byte_en;
  logic [1:0]        cmd_offset;
  logic [31:0]       cmd_addr;
  logic              cmd_line_first;
  logic              cmd_line_last;
  logic [3:0]        program_status_flags;
  logic              done_irq;
  logic              error_irq;
  logic              halted;
  logic              aborting;
  logic [3:0]        delay;
  logic              early_end;
  logic [3:0]        st;
  logic [31:0]       tgt;
  int                error_cnt;
  int                n_compared;
  int                cmd_cnt;
  int                cnt0;
  logic [3:0]        bad [12];

  pdd_decoder u_dut (
    .ref_clk, .reset, .program_enable, .instr_valid, .instr_word, .exec_done,
    .fifo_line_end, .instr_ready, .cmd_valid, .cmd_op, .cmd_count1, .cmd_count2,
    .cmd_count3, .cmd_byte_en, .cmd_offset, .cmd_addr, .cmd_line_first,
    .cmd_line_last, .program_status_flags, .done_irq, .error_irq, .halted, .aborting
  );
  pdd_exec_model u_exec (
    .ref_clk, .reset, .cmd_valid, .delay, .early_end, .exec_done, .fifo_line_end
  );

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (cmd_valid === 1'b1) cmd_cnt++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic wait_rdy;
    int k;
    k = 0;
    while (instr_ready !== 1'b1 && k < 60) begin
      @(negedge ref_clk);
      k++;
    end
    check(32'(k < 60), 32'h1);
  endtask : wait_rdy

  // words held until taken; ends at the falling edge after the last take
  task automatic send(input logic [31:0] w0, w1, w2, input int n);
    logic [31:0] w [3];
    w = '{w0, w1, w2};
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      instr_valid = 1'b1;
      instr_word = w[i];
      wait_rdy();
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask : send

  task automatic run(input logic [31:0] w0, w1, w2);
    logic [3:0]  op;
    logic [31:0] a;
    op = w0[31:28];
    a = (op == 4'hb) ? w2 : tgt;
    send(w0, w1, w2, (op == 4'hb) ? 3 : (op == 4'ha) ? 2 : 1);
    check(32'(cmd_valid), 32'h1);
    check(32'(cmd_count1), 32'(w0[11:0]));
    check(32'({cmd_line_first, cmd_line_last}), 32'(w0[27:26]));
    if (op == 4'h5 || op == 4'hb) check(cmd_addr, a);
    if (op != 4'ha) tgt = a + 32'(w0[11:0]);
    wait_rdy();
    st = (st & ~w0[19:16]) | w0[23:20];
    check(32'(program_status_flags), 32'(st));
    check(32'(done_irq), 32'(w0[24]));
  endtask : run

  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    program_enable = 1'b1;
    instr_valid = 1'b0;
    instr_word = 32'h0;
    delay = 4'h3;
    early_end = 1'b0;
    st = pdd_pkg::STATUS_RESET;
    tgt = pdd_pkg::ADDR_RESET;
    error_cnt = 0;
    n_compared = 0;
    cmd_cnt = 0;
    bad = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};
    repeat (8) @(negedge ref_clk);
    check(32'({cmd_valid, halted, instr_ready, error_irq}), 32'h0);
    reset = 1'b0;
    run(32'h5530_a010, 32'h0, 32'h0);
    check(32'(cmd_op), 32'(pdd_pkg::PDD_CMD_CONT_WRITE));
    check(32'(cmd_byte_en), 32'ha);
    delay = 4'h0;
    run(32'hbc82_f020, 32'h0456_0123, 32'h8000_1000);
    check(32'(cmd_op), 32'(pdd_pkg::PDD_CMD_LUMA_WRITE));
    check(32'({cmd_count3, cmd_count2}), 32'h0045_6123);
    run(32'h5044_0004, 32'h0, 32'h0);
    run(32'h2d0f_3fff, 32'h0, 32'h0);
    check(32'(cmd_op), 32'(pdd_pkg::PDD_CMD_DISCARD));
    check(32'(cmd_offset), 32'h3);
    run(32'ha560_00ab, 32'h00ef_00cd, 32'h0);
    check(32'(cmd_op), 32'(pdd_pkg::PDD_CMD_PLANAR_DISC));
    check(32'({cmd_count3, cmd_count2}), 32'h000e_f0cd);
    run(32'h5400_0001, 32'h0, 32'h0);
    // early line end drops the rest of the line
    early_end = 1'b1;
    send(32'h5000_0010, 32'h0, 32'h0, 1);
    repeat (4) @(negedge ref_clk);
    early_end = 1'b0;
    check(32'(aborting), 32'h1);
    cnt0 = cmd_cnt;
    send(32'h2000_0004, 32'h0, 32'h0, 1);
    send(32'h2400_0004, 32'h0, 32'h0, 1);
    check(32'(cmd_cnt - cnt0), 32'h0);
    check(32'(aborting), 32'h0);
    send(32'h5400_0002, 32'h0, 32'h0, 1);
    check(32'(cmd_valid), 32'h1);
    wait_rdy();
    foreach (bad[i]) begin
      send({bad[i], 28'h0}, 32'h0, 32'h0, 1);
      check(32'({error_irq, halted, instr_ready, cmd_valid}), 32'hc);
      program_enable = 1'b0;
      repeat (6) @(negedge ref_clk);
      check(32'(halted), 32'h1);
      program_enable = 1'b1;
      wait_rdy();
      check(32'(halted), 32'h0);
    end
    summarize();
  end

  // tests need well under 2000 cycles
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule : pdd_decoder_tb_top
